// >>> verilog/mode_sense_pkg.sv
/*
 * Shared constants and types for the bus mode sense and debounce logic.
 * Assumes a 100 MHz core clock; comparator outputs arrive asynchronously.
 */
package mode_sense_pkg;

    // Sensed or held transmission mode
    typedef enum logic [1:0] {
        MODE_SE  = 2'h0,
        MODE_LVD = 2'h1,
        MODE_HVD = 2'h3,
        MODE_IND = 2'h2
    } bus_mode_t;

    // Power-up sequence, Gray coded along the usual path
    typedef enum logic [1:0] {
        PU_WAIT_OPER   = 2'h0,
        PU_WAIT_STABLE = 2'h1,
        PU_RUN         = 2'h3
    } pu_state_t;

    // Raw comparator levels, one per threshold
    typedef struct packed {
        logic above_se;   // Above the top of the SE band
        logic above_lvd;  // Above the bottom of the LVD band
        logic below_lvd;  // Below the top of the LVD band
        logic above_hvd;  // Above the bottom of the HVD band
    } sense_cmp_t;

    // Driver and termination controls
    typedef struct packed {
        logic drv_en;      // Assertion and negation drivers may leave high-Z
        logic se_sel;      // Single-ended operation
        logic lvd_sel;     // Low-voltage differential operation
        logic gnd_drv_en;  // Ground drivers on
        logic term_se;     // Terminator in SE termination mode
        logic term_lvd;    // Terminator in LVD termination mode
    } bus_ctl_t;

    localparam int unsigned CLK_HZ        = 100_000_000;
    localparam int unsigned PERSIST_MS    = 100;
    localparam int unsigned PERSIST_CYC   = CLK_HZ / 1000 * PERSIST_MS;
    localparam int unsigned TIMER_W       = 24;

endpackage : mode_sense_pkg

// >>> verilog/mode_classify.sv
/*
 * Comparator decoder: turns the synchronised threshold levels into a mode.
 * Assumes inputs are already synchronised to i_core_clk.
 */
`timescale 1ns/1ns
`default_nettype none
module mode_classify
    import mode_sense_pkg::*;
(
    input  wire sense_cmp_t i_cmp,
    output var  bus_mode_t  o_mode
);

    // A low above_se alone names SE; LVD and HVD need their band bits; the bands between are indeterminate
    always_comb begin
        if (!i_cmp.above_se) begin
            o_mode = MODE_SE;
        end else if (i_cmp.above_lvd && i_cmp.below_lvd && !i_cmp.above_hvd) begin
            o_mode = MODE_LVD;
        end else if (i_cmp.above_hvd && !i_cmp.below_lvd) begin
            o_mode = MODE_HVD;
        end else begin
            o_mode = MODE_IND;
        end
    end

endmodule // mode_classify
`default_nettype wire

// >>> verilog/bus_mode_sense_debounce.sv
/*
 * Mode sense debounce: synchronises the sense-line comparators, filters mode
 * changes over a persistence window and drives transceiver, terminator and
 * ground driver controls. Mode changes are slow on purpose, so the pins never
 * follow a sense-line glitch. Assumes a free-running clock and a power-on reset;
 * comparator outputs are asynchronous and may chatter near a band edge.
 */
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - Drivers high-Z for 100 ms after power-on
// - Then wait 100 ms of stable mode
// - Mode changes only after 100 ms persistence
// - Classify SE, LVD, HVD; gaps indeterminate
// - Transceiver mode follows the sensed mode
// - HVD sensed puts all drivers high-Z
// - Terminator mode follows sensed mode
// - Terminator sources LVD level while monitoring
// - Grounded sense line means SE
// - Terminator ground driver on during SE
// - Transceiver ground drivers on during SE
module bus_mode_sense_debounce
    import mode_sense_pkg::*;
#(
    parameter int unsigned PERSIST_CYCLES = PERSIST_CYC
) (
    input  wire logic       i_core_clk,
    input  wire logic       i_sys_rst,
    input  wire logic       i_clk_en,
    input  wire sense_cmp_t i_sense_cmp,
    output logic            o_sense_src_en,
    output bus_ctl_t        o_bus_ctl,
    output bus_mode_t       o_mode,
    output logic            o_mode_valid
);

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(PERSIST_CYCLES - 1);

    typedef struct packed {
        sense_cmp_t        sync1;
        sense_cmp_t        sync2;
        pu_state_t         pu;
        bus_mode_t         cur;
        bus_mode_t         cand;
        logic [TIMER_W-1:0] timer;
        bus_ctl_t          ctl;
    } state_t;

    state_t    st_q;
    state_t    st_d;
    bus_mode_t raw_mode;

    // Decoder sees only the second synchroniser stage
    mode_classify u_classify (
        .i_cmp  (st_q.sync2),
        .o_mode (raw_mode)
    );

    // Timer helper: saturates at the last count
    function automatic logic [TIMER_W-1:0] tick(input logic [TIMER_W-1:0] t);
        return (t == TIMER_LAST) ? t : t + TIMER_W'(1);
    endfunction

    // Pin controls for a power-up state and held mode; all off until running
    function automatic bus_ctl_t ctl_of(input pu_state_t p, input bus_mode_t m);
        bus_ctl_t c;
        c = '0;
        if (p == PU_RUN) begin
            c.drv_en     = (m != MODE_HVD);
            c.se_sel     = (m == MODE_SE);
            c.lvd_sel    = (m == MODE_LVD);
            c.gnd_drv_en = (m == MODE_SE);
            c.term_se    = (m == MODE_SE);
            c.term_lvd   = (m == MODE_LVD);
        end
        return c;
    endfunction

    // Next-state logic
    always_comb begin
        st_d       = st_q;
        // Two-stage synchroniser; only the second stage feeds the decoder
        st_d.sync1 = i_sense_cmp;
        st_d.sync2 = st_q.sync1;
        case (st_q.pu)
            // Wait for logic to be operational for the whole window
            PU_WAIT_OPER: begin
                st_d.timer = tick(st_q.timer);
                if (st_q.timer == TIMER_LAST) begin
                    st_d.pu    = PU_WAIT_STABLE;
                    st_d.timer = '0;
                    st_d.cand  = raw_mode;
                end
            end
            // Mode must hold unbroken for another window
            PU_WAIT_STABLE: begin
                if (raw_mode != st_q.cand || raw_mode == MODE_IND) begin
                    st_d.cand  = raw_mode;
                    st_d.timer = '0;
                end else if (st_q.timer == TIMER_LAST) begin
                    st_d.pu  = PU_RUN;
                    st_d.cur = st_q.cand;
                end else begin
                    st_d.timer = tick(st_q.timer);
                end
            end
            // Running: a new mode must persist before it is adopted
            PU_RUN: begin
                if (raw_mode == st_q.cur || raw_mode == MODE_IND) begin
                    st_d.cand  = st_q.cur;
                    st_d.timer = '0;
                end else if (raw_mode != st_q.cand) begin
                    st_d.cand  = raw_mode;
                    st_d.timer = '0;
                end else if (st_q.timer == TIMER_LAST) begin
                    st_d.cur   = st_q.cand;
                    st_d.timer = '0;
                end else begin
                    st_d.timer = tick(st_q.timer);
                end
            end
            default: begin
                st_d.pu    = PU_WAIT_OPER;
                st_d.timer = '0;
            end
        endcase

        // Controls come from the power-up state and held mode only, registered for glitch-free pins
        st_d.ctl = ctl_of(st_d.pu, st_d.cur);
    end

    // State register; enable freezes everything
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q      <= '0;
            st_q.pu   <= PU_WAIT_OPER;
            st_q.cur  <= MODE_IND;
            st_q.cand <= MODE_IND;
        end else if (i_clk_en) begin
            st_q <= st_d;
        end
    end

    // The LVD source stays on so the line is sensed while driven
    assign o_sense_src_en = 1'b1;
    assign o_bus_ctl      = st_q.ctl;
    assign o_mode         = st_q.cur;
    // Run decode cannot glitch: the last step into run flips one bit
    assign o_mode_valid   = (st_q.pu == PU_RUN);

    // Checks beside the logic; they sample registered state and its decode
    a_hiz_until_run: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (st_q.pu != PU_RUN) |-> !o_bus_ctl.drv_en)
        else $error("drivers enabled before power-up done");
    a_stable_entry: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_WAIT_STABLE && raw_mode != st_q.cand)
        |=> st_q.pu == PU_WAIT_STABLE)
        else $error("run entered on unstable mode");
    a_mode_hold: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (st_q.pu == PU_RUN && st_q.cur != $past(st_q.cur)) |->
        $past(st_q.timer) == TIMER_LAST)
        else $error("mode changed without persistence");
    a_ind_restart: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_RUN && raw_mode == MODE_IND)
        |=> st_q.timer == '0 && $stable(st_q.cur))
        else $error("indeterminate did not restart timer");
    a_hvd_hiz: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (st_q.cur == MODE_HVD) |-> !o_bus_ctl.drv_en && !o_bus_ctl.gnd_drv_en)
        else $error("driver on in HVD");
    a_se_ground: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode_valid && st_q.cur == MODE_SE) |->
        o_bus_ctl.gnd_drv_en && o_bus_ctl.term_se && o_bus_ctl.se_sel)
        else $error("ground driver off in SE");
    a_lvd_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode_valid && st_q.cur == MODE_LVD) |->
        o_bus_ctl.lvd_sel && o_bus_ctl.term_lvd && !o_bus_ctl.gnd_drv_en)
        else $error("LVD select wrong");
    // Grounded line while another mode is held must become the pending mode
    a_gnd_sense_se: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_RUN && !st_q.sync2.above_se && st_q.cur != MODE_SE)
        |=> st_q.cand == MODE_SE)
        else $error("grounded line not taken as SE");
    a_hvd_no_select: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (o_mode_valid && st_q.cur == MODE_HVD) |-> !o_bus_ctl.se_sel && !o_bus_ctl.lvd_sel)
        else $error("mode select on in HVD");

    // Power-up sequencing: each window must run to its last count
    a_oper_window: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_WAIT_OPER && st_q.timer != TIMER_LAST)
        |=> st_q.pu == PU_WAIT_OPER)
        else $error("operational window cut short");
    a_oper_exit: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_WAIT_OPER && st_q.timer == TIMER_LAST)
        |=> st_q.pu == PU_WAIT_STABLE && st_q.timer == '0)
        else $error("stable window not started");
    a_ind_stable_wait: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_WAIT_STABLE && raw_mode == MODE_IND)
        |=> st_q.pu == PU_WAIT_STABLE && st_q.timer == '0)
        else $error("indeterminate let the stable window run");

    // Once running, only a reset brings the drivers back to the power-up wait
    a_run_sticky: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        st_q.pu == PU_RUN |=> st_q.pu == PU_RUN)
        else $error("left run state without reset");

    // A fresh candidate restarts the count; only a full count adopts it
    a_new_cand: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_RUN && raw_mode != MODE_IND && raw_mode != st_q.cur
            && raw_mode != st_q.cand)
        |=> st_q.timer == '0 && st_q.cand == $past(raw_mode) && $stable(st_q.cur))
        else $error("new mode did not restart persistence");
    a_adopt_full: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        (i_clk_en && st_q.pu == PU_RUN && raw_mode == st_q.cand && raw_mode != st_q.cur
            && raw_mode != MODE_IND && st_q.timer == TIMER_LAST)
        |=> st_q.cur == $past(st_q.cand))
        else $error("persisted mode not adopted");

    // Clock enable low must freeze every register, timers and synchronisers too
    a_en_freeze: assert property (@(posedge i_core_clk) disable iff (i_sys_rst)
        !i_clk_en |=> $stable(st_q))
        else $error("state moved while clock enable low");

endmodule // bus_mode_sense_debounce
`default_nettype wire

// >>> dv/sense_line_model.sv
/*
 * Far-side model of the mode-sense line: turns the level set by the other
 * bus parties into the four comparator outputs. Assumes settled levels.
 */
`timescale 1ns/1ns
`default_nettype none
module sense_line_model
    import mode_sense_pkg::*;
(
    input  wire bus_mode_t  i_level,
    output var  sense_cmp_t o_cmp
);
    // Pattern per band; anything else lands in a gap between bands
    always_comb begin
        case (i_level)
            MODE_SE:  o_cmp = 4'h0; // Grounded line, no comparator tripped
            MODE_LVD: o_cmp = 4'he;
            MODE_HVD: o_cmp = 4'hd;
            default:  o_cmp = 4'ha;
        endcase
    end
endmodule // sense_line_model
`default_nettype wire

// >>> dv/tb_top.sv
/*
 * Self-checking bench for the mode sense debounce with a short window.
 * Assumes the sense-line model and the package compile first.
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import mode_sense_pkg::*;
    localparam int P = 20;
    logic       i_core_clk = 1'b0;
    logic       i_sys_rst, i_clk_en, src_en, valid;
    bus_mode_t  level, mode;
    sense_cmp_t cmp;
    bus_ctl_t   ctl;
    int         fail_count, checks_done, cyc;

    sense_line_model line (.i_level(level), .o_cmp(cmp));
    bus_mode_sense_debounce #(.PERSIST_CYCLES(P)) DUT (.i_core_clk(i_core_clk),
        .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en), .i_sense_cmp(cmp),
        .o_sense_src_en(src_en), .o_bus_ctl(ctl), .o_mode(mode), .o_mode_valid(valid));

    // Clock and hang guard
    initial begin
        forever #5 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic hold(bus_mode_t m, int n);
        level = m;
        repeat (n) @(negedge i_core_clk);
    endtask

    // Bounded wait for adoption, then judge mode and controls together
    task automatic expect_mode(bus_mode_t m, logic [5:0] c);
        for (int i = 0; i < 3 * P && mode !== m; i++) @(negedge i_core_clk);
        check("mode", 8'(mode), 8'(m));
        check("ctl", 8'(ctl), 8'(c));
    endtask

    task automatic test_power_up;
        for (int i = 0; i < 2 * P; i++) begin
            check("drv_en early", 8'(ctl.drv_en), 8'h0);
            check("valid early", 8'(valid), 8'h0);
            @(negedge i_core_clk);
        end
        expect_mode(MODE_SE, 6'h36);
        check("valid", 8'(valid), 8'h1);
        check("src_en", 8'(src_en), 8'h1);
        $display("power-up test done");
    endtask

    task automatic test_persist;
        hold(MODE_LVD, P - 3);
        hold(MODE_SE, 5);
        check("short change", 8'(mode), 8'(MODE_SE));
        hold(MODE_LVD, P - 3);
        hold(MODE_IND, 1);
        hold(MODE_LVD, P - 3);
        check("broken change", 8'(mode), 8'(MODE_SE));
        hold(MODE_SE, 5);
        // Frozen clock enable must stop the window from running
        i_clk_en = 1'b0;
        hold(MODE_LVD, 3 * P);
        check("frozen", 8'(mode), 8'(MODE_SE));
        i_clk_en = 1'b1;
        hold(MODE_LVD, P - 1);
        check("early adopt", 8'(mode), 8'(MODE_SE));
        expect_mode(MODE_LVD, 6'h29);
        $display("persistence test done");
    endtask

    task automatic test_hvd;
        hold(MODE_HVD, 1);
        expect_mode(MODE_HVD, 6'h00);
        hold(MODE_IND, 3 * P);
        check("ind held", 8'(mode), 8'(MODE_HVD));
        hold(MODE_SE, 1);
        expect_mode(MODE_SE, 6'h36);
        $display("hvd test done");
    endtask

    // Mid-run reset, then a break inside the stable-mode window
    task automatic test_restart;
        i_sys_rst = 1'b1;
        hold(MODE_LVD, 2);
        i_sys_rst = 1'b0;
        check("mode after reset", 8'(mode), 8'(MODE_IND));
        check("ctl after reset", 8'(ctl), 8'h00);
        hold(MODE_LVD, P + 5);
        hold(MODE_IND, 1);
        hold(MODE_LVD, P);
        check("drv_en after break", 8'(ctl.drv_en), 8'h0);
        check("valid after break", 8'(valid), 8'h0);
        expect_mode(MODE_LVD, 6'h29);
        check("valid", 8'(valid), 8'h1);
        $display("restart test done");
    endtask

    task automatic finish_test;
        $display("checks_done=%0d fail_count=%0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // Main sequence, inputs moved on the falling edge
    initial begin
        {fail_count, checks_done, cyc} = '0;
        i_sys_rst = 1'b1;
        i_clk_en = 1'b1;
        level = MODE_SE;
        repeat (6) @(negedge i_core_clk);
        i_sys_rst = 1'b0;
        test_power_up();
        test_persist();
        test_hvd();
        test_restart();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
